// ---- verilog/ic_params.svh ----
// Constants for the instruction cache: geometry, register map, field positions, reset values
`ifndef IC_PARAMS_SVH
`define IC_PARAMS_SVH
// Geometry: 512 lines of 8 words as 16 sets of 32 ways
`define IC_WAYS 32
`define IC_SETS 16
`define IC_WORDS 8
`define IC_LINES 512
`define IC_WAY_W 5
`define IC_SET_W 4
`define IC_WORD_W 3
`define IC_TAG_W 23
`define IC_TAG_LSB 9
`define IC_SET_LSB 5
`define IC_WORD_LSB 2
`define IC_LAST_WORD 3'h7
// Register byte offsets on the bus
`define IC_ADR_W 8
`define IC_REG_CTRL 8'h04
`define IC_REG_CACHEOP 8'h1C
`define IC_REG_STATUS 8'h20
`define IC_REG_HITS 8'h24
`define IC_REG_MISSES 8'h28
// Control register fields and reset value
`define IC_CTRL_MMU_BIT 0
`define IC_CTRL_EN_BIT 12
`define IC_CTRL_MASK 32'h0000_1001
`define IC_CTRL_RST 32'h0000_0000
// Cache operation code for invalidate-all, held in the low nibble of the write data
`define IC_OP_INV_ALL 4'h5
`endif

// ---- verilog/ic_pkg.sv ----
// Types shared by the instruction cache modules
package ic_pkg;
`include "ic_params.svh"

   typedef enum logic [2:0] {IC_IDLE, IC_READ, IC_FILL, IC_SINGLE, IC_DONE} ic_state_type;

   typedef struct packed {
      ic_state_type state;
      logic [31:0] addr;
      logic [31:0] word;
      logic [`IC_WORD_W-1:0] cnt;
      logic [`IC_WAY_W-1:0] way;
      logic last_hit;
      logic [31:0] hits;
      logic [31:0] misses;
   } ic_core_st_type;

   typedef struct packed {
      logic [31:0] ctrl;
      logic ack;
      logic [31:0] rdata;
      logic inv;
   } ic_reg_st_type;

   typedef struct packed {
      logic [`IC_LINES-1:0] valid;
      logic [`IC_SETS-1:0][`IC_WAY_W-1:0] rr;
   } ic_tag_st_type;
endpackage

// ---- verilog/ic_if.sv ----
// Interfaces between the cache core, its tag store and its register block
`timescale 1ns/1ps
`include "ic_params.svh"

interface ic_tag_if;
   logic [`IC_SET_W-1:0] set;
   logic [`IC_TAG_W-1:0] tag;
   logic hit;
   logic [`IC_WAY_W-1:0] hit_way;
   logic [`IC_WAY_W-1:0] victim;
   logic alloc;
   logic [`IC_SET_W-1:0] alloc_set;
   logic [`IC_TAG_W-1:0] alloc_tag;
   logic [`IC_WAY_W-1:0] alloc_way;
   logic inv_all;
   modport core (output set, tag, alloc, alloc_set, alloc_tag, alloc_way, inv_all,
                 input hit, hit_way, victim);
   modport store (input set, tag, alloc, alloc_set, alloc_tag, alloc_way, inv_all,
                  output hit, hit_way, victim);
endinterface

interface ic_ctl_if;
   logic mmu_en;
   logic cache_en;
   logic inv_all;
   logic busy;
   logic last_hit;
   logic [31:0] hits;
   logic [31:0] misses;
   modport regs (output mmu_en, cache_en, inv_all, input busy, last_hit, hits, misses);
   modport core (input mmu_en, cache_en, inv_all, output busy, last_hit, hits, misses);
endinterface

// ---- verilog/ic_tag_store.sv ----
// Tag store: valid bits, tags and round-robin victim pointers for all sets
`timescale 1ns/1ps
`include "ic_params.svh"

module ic_tag_store
   import ic_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Lookup and allocate port
   ic_tag_if.store tag_if
);
   logic [`IC_TAG_W-1:0] tag_mem [0:`IC_LINES-1];
   ic_tag_st_type st_ff;
   ic_tag_st_type nxt_st;
   logic [`IC_WAYS-1:0] hit_vec;

   // Lowest set bit of a way vector as a way number
   function automatic logic [`IC_WAY_W-1:0] ic_way_index(input logic [`IC_WAYS-1:0] v);
      logic [`IC_WAY_W-1:0] r;
      r = '0;
      for (int i = `IC_WAYS - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = i[`IC_WAY_W-1:0];
         end
      end
      return r;
   endfunction

   // Compare all 32 ways of the set at once
   genvar g;
   generate
      for (g = 0; g < `IC_WAYS; g++) begin : gen_cmp
         assign hit_vec[g] = st_ff.valid[{tag_if.set, 5'(g)}] &&
                             (tag_mem[{tag_if.set, 5'(g)}] == tag_if.tag);
      end
   endgenerate

   assign tag_if.hit = |hit_vec;
   assign tag_if.hit_way = ic_way_index(hit_vec);
   assign tag_if.victim = st_ff.rr[tag_if.set];

   // Invalidate-all, then line allocation with pointer advance
   always_comb begin
      nxt_st = st_ff;
      if (tag_if.inv_all) begin
         nxt_st.valid = '0;
      end
      if (tag_if.alloc) begin
         nxt_st.valid[{tag_if.alloc_set, tag_if.alloc_way}] = 1'b1;
         nxt_st.rr[tag_if.alloc_set] = st_ff.rr[tag_if.alloc_set] + 5'h01;
      end
   end

   // State register; hardware reset flushes every line and rewinds pointers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Tag array write on allocation
   always_ff @(posedge clk_i) begin
      if (tag_if.alloc) begin
         tag_mem[{tag_if.alloc_set, tag_if.alloc_way}] <= tag_if.alloc_tag;
      end
   end
endmodule

// ---- verilog/ic_regs.sv ----
// Wishbone register block: control, cache operation, status and counters
`timescale 1ns/1ps
`include "ic_params.svh"

module ic_regs
   import ic_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Reset sequences that turn the cache off
   input wire logic soft_rst_i,
   input wire logic sleep_rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`IC_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Control to the core
   ic_ctl_if.regs ctl_if
);
   ic_reg_st_type st_ff;
   ic_reg_st_type nxt_st;
   localparam logic [31:0] CTRL_MASK = `IC_CTRL_MASK;
   logic access;

   assign access = wb_cyc_i && wb_stb_i && !st_ff.ack;

   // Decode, write and read mux
   always_comb begin
      nxt_st = st_ff;
      nxt_st.ack = 1'b0;
      nxt_st.inv = 1'b0;
      if (access) begin
         nxt_st.ack = 1'b1;
         nxt_st.rdata = '0;
         if (wb_adr_i == `IC_REG_CTRL) begin
            if (wb_we_i) begin
               for (int i = 0; i < 4; i++) begin
                  if (wb_sel_i[i]) begin
                     nxt_st.ctrl[8*i+:8] = wb_dat_i[8*i+:8] & CTRL_MASK[8*i+:8];
                  end
               end
            end
            nxt_st.rdata = st_ff.ctrl;
         end else if (wb_adr_i == `IC_REG_CACHEOP) begin
            if (wb_we_i && wb_sel_i[0] && (wb_dat_i[3:0] == `IC_OP_INV_ALL)) begin
               nxt_st.inv = 1'b1;
            end
         end else if (wb_adr_i == `IC_REG_STATUS) begin
            nxt_st.rdata = {28'h0000000, ctl_if.last_hit, ctl_if.busy,
                            st_ff.ctrl[`IC_CTRL_EN_BIT], st_ff.ctrl[`IC_CTRL_MMU_BIT]};
         end else if (wb_adr_i == `IC_REG_HITS) begin
            nxt_st.rdata = ctl_if.hits;
         end else if (wb_adr_i == `IC_REG_MISSES) begin
            nxt_st.rdata = ctl_if.misses;
         end
      end
      if (soft_rst_i || sleep_rst_i) begin
         nxt_st.ctrl[`IC_CTRL_EN_BIT] = 1'b0;
      end
   end

   // State register; hardware reset clears the enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= '0;
         st_ff.ctrl <= `IC_CTRL_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign wb_ack_o = st_ff.ack;
   assign wb_dat_o = st_ff.rdata;
   assign ctl_if.mmu_en = st_ff.ctrl[`IC_CTRL_MMU_BIT];
   assign ctl_if.cache_en = st_ff.ctrl[`IC_CTRL_EN_BIT];
   assign ctl_if.inv_all = st_ff.inv;
endmodule

// ---- verilog/ic_top.sv ----
// Instruction cache top: fetch lookup, line fills, uncached fetches, register block
`timescale 1ns/1ps
`include "ic_params.svh"

// Overview of operation
// - The cache holds 512 lines of 32 bytes in 16 sets of 32 ways, indexed and tagged by virtual address.
// - A fill always brings in a whole line of eight words, never part of one.
// - Hardware reset, a software reset or a sleep reset turns the cache off.
// - With memory management off every address counts as cacheable.
// - Every fetch looks up the cache; the cacheable attribute matters only on a miss.
// - A miss with the cache enabled that is cacheable or has memory management off fetches eight words into the round-robin way.
// - A miss with memory management on and the attribute clear reads one word and leaves the cache alone.
// - Fetches and fills never look at data stores or the write buffer.
// - Writing the invalidate code to cache operation register 7 invalidates every line at once.
// - Fetches already under way when the invalidate is written may still hit in the cache.
// - Hardware reset invalidates all lines as well as clearing the enable.
// - While disabled no lines are allocated but lookups still go on and hits are served.
// - Control register bit 12 is the cache enable that permits allocation.
// - One control write can switch memory management and the cache on together.
module ic_top
   import ic_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Reset sequences that turn the cache off
   input wire logic soft_rst_i,
   input wire logic sleep_rst_i,
   // Wishbone register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`IC_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Fetch port from the core
   input wire logic fetch_req_i,
   input wire logic [31:0] fetch_addr_i,
   input wire logic fetch_cacheable_i,
   output logic fetch_ready_o,
   output logic fetch_valid_o,
   output logic [31:0] fetch_data_o,
   // External memory read port
   output logic mem_req_o,
   output logic mem_line_o,
   output logic [31:0] mem_addr_o,
   input wire logic mem_ack_i,
   input wire logic [31:0] mem_data_i
);
   ic_core_st_type st_ff;
   ic_core_st_type nxt_st;
   ic_tag_if tag_if ();
   ic_ctl_if ctl_if ();

   // Line data, one word per entry, addressed by set, way and word
   logic [31:0] data_mem [0:`IC_LINES*`IC_WORDS-1];
   logic [31:0] rd_word_ff;
   logic [`IC_SET_W+`IC_WAY_W+`IC_WORD_W-1:0] rd_idx;
   logic [`IC_SET_W+`IC_WAY_W+`IC_WORD_W-1:0] wr_idx;
   logic [31:0] look_addr;
   logic alloc_ok;
   logic alloc;

   // Register block
   ic_regs u_regs (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .soft_rst_i(soft_rst_i),
      .sleep_rst_i(sleep_rst_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .ctl_if(ctl_if)
   );

   // Tag store
   ic_tag_store u_tags (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tag_if(tag_if)
   );

   // Lookup uses the incoming address while idle, the held one otherwise
   assign look_addr = (st_ff.state == IC_IDLE) ? fetch_addr_i : st_ff.addr;
   assign tag_if.set = look_addr[`IC_SET_LSB+:`IC_SET_W];
   assign tag_if.tag = look_addr[`IC_TAG_LSB+:`IC_TAG_W];
   assign tag_if.inv_all = ctl_if.inv_all;
   assign tag_if.alloc = alloc;
   assign tag_if.alloc_set = st_ff.addr[`IC_SET_LSB+:`IC_SET_W];
   assign tag_if.alloc_tag = st_ff.addr[`IC_TAG_LSB+:`IC_TAG_W];
   assign tag_if.alloc_way = st_ff.way;

   // Allocation only when enabled, and cacheable or memory management off
   assign alloc_ok = ctl_if.cache_en && (fetch_cacheable_i || !ctl_if.mmu_en);

   // Status back to the register block
   assign ctl_if.busy = (st_ff.state != IC_IDLE);
   assign ctl_if.last_hit = st_ff.last_hit;
   assign ctl_if.hits = st_ff.hits;
   assign ctl_if.misses = st_ff.misses;

   // Data array indices for the hit read and the fill write
   assign rd_idx = {fetch_addr_i[`IC_SET_LSB+:`IC_SET_W], tag_if.hit_way,
                    fetch_addr_i[`IC_WORD_LSB+:`IC_WORD_W]};
   assign wr_idx = {st_ff.addr[`IC_SET_LSB+:`IC_SET_W], st_ff.way, st_ff.cnt};

   // Fetch sequencing: lookup, hit read, line fill or single-word read
   always_comb begin
      nxt_st = st_ff;
      alloc = 1'b0;
      case (st_ff.state)
         IC_IDLE: begin
            if (fetch_req_i) begin
               nxt_st.addr = fetch_addr_i;
               nxt_st.cnt = '0;
               if (tag_if.hit) begin
                  // Hit served whatever the enable or attribute
                  nxt_st.way = tag_if.hit_way;
                  nxt_st.last_hit = 1'b1;
                  nxt_st.hits = st_ff.hits + 32'h0000_0001;
                  nxt_st.state = IC_READ;
               end else begin
                  nxt_st.last_hit = 1'b0;
                  nxt_st.misses = st_ff.misses + 32'h0000_0001;
                  if (alloc_ok) begin
                     nxt_st.way = tag_if.victim;
                     nxt_st.state = IC_FILL;
                  end else begin
                     nxt_st.state = IC_SINGLE;
                  end
               end
            end
         end
         IC_READ: begin
            nxt_st.word = rd_word_ff;
            nxt_st.state = IC_DONE;
         end
         IC_FILL: begin
            if (mem_ack_i) begin
               if (st_ff.cnt == st_ff.addr[`IC_WORD_LSB+:`IC_WORD_W]) begin
                  nxt_st.word = mem_data_i;
               end
               nxt_st.cnt = st_ff.cnt + 3'h1;
               if (st_ff.cnt == `IC_LAST_WORD) begin
                  // Line marked valid only once all eight words are in
                  alloc = 1'b1;
                  nxt_st.state = IC_DONE;
               end
            end
         end
         IC_SINGLE: begin
            if (mem_ack_i) begin
               nxt_st.word = mem_data_i;
               nxt_st.state = IC_DONE;
            end
         end
         IC_DONE: begin
            nxt_st.state = IC_IDLE;
         end
         default: begin
            nxt_st.state = IC_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= '0;
         st_ff.state <= IC_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Data array: fill writes and registered hit read
   always_ff @(posedge clk_i) begin
      if ((st_ff.state == IC_FILL) && mem_ack_i) begin
         data_mem[wr_idx] <= mem_data_i;
      end
      rd_word_ff <= data_mem[rd_idx];
   end

   // Fetch answer
   assign fetch_ready_o = (st_ff.state == IC_IDLE);
   assign fetch_valid_o = (st_ff.state == IC_DONE);
   assign fetch_data_o = st_ff.word;

   // Memory request; only fetch traffic, no store snooping
   assign mem_req_o = (st_ff.state == IC_FILL) || (st_ff.state == IC_SINGLE);
   assign mem_line_o = (st_ff.state == IC_FILL);
   assign mem_addr_o = (st_ff.state == IC_FILL) ? {st_ff.addr[31:`IC_SET_LSB], 5'h00} :
                       {st_ff.addr[31:`IC_WORD_LSB], 2'h0};
endmodule

// ---- testbench/ic_mem_model.sv ----
// Behavioural external memory for line fills and single-word reads
`timescale 1ns/1ps
module ic_mem_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Idle cycles before each returned word
   input wire logic [3:0] gap_i,
   // Memory read port
   input wire logic mem_req_i,
   input wire logic mem_line_i,
   input wire logic [31:0] mem_addr_i,
   output logic mem_ack_o,
   output logic [31:0] mem_data_o
);
   logic [3:0] cnt_ff;
   logic [3:0] wait_ff;
   // Words go out in ascending order; the data bus toggles when no word is offered
   always_ff @(posedge clk_i) begin
      mem_ack_o <= 1'b0;
      mem_data_o <= ~mem_data_o;
      if (rst_i || !mem_req_i) begin
         cnt_ff <= 4'h0;
         wait_ff <= gap_i;
         if (rst_i)
            mem_data_o <= 32'h0;
      end else if (cnt_ff < (mem_line_i ? 4'h8 : 4'h1)) begin
         if (wait_ff != 4'h0)
            wait_ff <= wait_ff - 4'h1;
         else begin
            mem_ack_o <= 1'b1;
            mem_data_o <= {mem_addr_i[31:5], mem_addr_i[4:2] + cnt_ff[2:0], 2'b00} ^ 32'hC0DE_0000;
            cnt_ff <= cnt_ff + 4'h1;
            wait_ff <= gap_i;
         end
      end
   end
endmodule

// ---- testbench/ic_top_asserts.sv ----
// Concurrent checks on the instruction cache top ports
`timescale 1ns/1ps
module ic_top_asserts (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // Fetch port
   input wire logic fetch_req_i,
   input wire logic fetch_ready_o,
   input wire logic fetch_valid_o,
   // Memory port
   input wire logic mem_req_o,
   input wire logic mem_line_o,
   input wire logic [31:0] mem_addr_o,
   input wire logic mem_ack_i
);
   logic [3:0] acks_ff;
   logic [3:0] nxt_acks;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Counts words returned within the current memory read
   always_comb begin
      nxt_acks = acks_ff;
      if (!mem_req_o)
         nxt_acks = 4'h0;
      else if (mem_ack_i)
         nxt_acks = acks_ff + 4'h1;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i)
         acks_ff <= 4'h0;
      else
         acks_ff <= nxt_acks;
   end
   a_bus_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not acked next cycle");
   a_bus_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack longer than one cycle");
   a_bus_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("bus ack without request");
   a_take_busy: assert property (fetch_req_i && fetch_ready_o |=> !fetch_ready_o [*2])
      else $error("fetch port ready too soon after take");
   a_valid_release: assert property (fetch_valid_o |=> !fetch_valid_o && fetch_ready_o)
      else $error("fetch answer not a single pulse");
   a_hit_answer: assert property (fetch_req_i && fetch_ready_o ##1 !mem_req_o |=> fetch_valid_o)
      else $error("hit not answered on time");
   a_fill_aligned: assert property ($rose(mem_req_o) && mem_line_o |-> mem_addr_o[4:0] == 5'h00)
      else $error("line fill address not line aligned");
   a_req_holds: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
      else $error("memory request changed before its word");
   a_line_count: assert property (mem_req_o && mem_line_o && mem_ack_i && acks_ff != 4'h7 |=> mem_req_o)
      else $error("line fill ended before eight words");
   a_line_done: assert property (mem_line_o && mem_ack_i && acks_ff == 4'h7 |=> !mem_req_o && fetch_valid_o)
      else $error("line fill not closed after eight words");
   a_single_done: assert property (mem_req_o && !mem_line_o && mem_ack_i |=> !mem_req_o && fetch_valid_o)
      else $error("single read not closed after one word");
endmodule
bind ic_top ic_top_asserts u_asserts (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .fetch_req_i(fetch_req_i), .fetch_ready_o(fetch_ready_o),
   .fetch_valid_o(fetch_valid_o), .mem_req_o(mem_req_o), .mem_line_o(mem_line_o),
   .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i));

// ---- testbench/test_ic_top.sv ----
// Self-checking bench for the instruction cache top
`timescale 1ns/1ps
`include "ic_params.svh"
module test_ic_top
   import ic_pkg::*;
;
   logic clk_i, rst_i, soft_rst_i, sleep_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [3:0] gap;
   logic [31:0] wb_dat_i, wb_dat_o, rd, fetch_addr_i, fetch_data_o, mem_addr_o, mem_data_i;
   logic fetch_req_i, fetch_cacheable_i, fetch_ready_o, fetch_valid_o, mem_req_o, mem_line_o, mem_ack_i;
   logic mreq_d = 1'b0;
   int err_total = 0;
   int checks = 0;
   int n_fill = 0;
   int n_single = 0;
   ic_top uut (.clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i), .sleep_rst_i(sleep_rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fetch_req_i(fetch_req_i),
      .fetch_addr_i(fetch_addr_i), .fetch_cacheable_i(fetch_cacheable_i), .fetch_ready_o(fetch_ready_o),
      .fetch_valid_o(fetch_valid_o), .fetch_data_o(fetch_data_o), .mem_req_o(mem_req_o),
      .mem_line_o(mem_line_o), .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .mem_data_i(mem_data_i));
   ic_mem_model u_mem (.clk_i(clk_i), .rst_i(rst_i), .gap_i(gap), .mem_req_i(mem_req_o),
      .mem_line_i(mem_line_o), .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i), .mem_data_o(mem_data_i));
   // Clock at 100 ns
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // Counts memory reads by kind as they start
   always @(posedge clk_i) begin
      mreq_d <= mem_req_o;
      if (mem_req_o === 1'b1 && mreq_d === 1'b0) begin
         if (mem_line_o)
            n_fill++;
         else
            n_single++;
      end
   end
   function automatic logic [31:0] mem_word(input logic [31:0] a);
      return {a[31:2], 2'b00} ^ 32'hC0DE_0000;
   endfunction
   task automatic summarize;
      if (err_total == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp_kind(input string what, input int exp, input int got);
      checks++;
      if (got != exp) begin
         err_total++;
         $display("BAD %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic hw_reset;
      rst_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask
   // Classic single bus cycle, held until ack is sampled
   task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      cmp_word("bus ack", 32'h1, {31'h0, wb_ack_o});
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task automatic reg_chk(input logic [7:0] adr, input logic [31:0] exp);
      bus(1'b0, adr, 32'h0);
      cmp_word("register read", exp, rd);
   endtask
   // Fetch one word; kind 0 hit, 1 line fill, 2 single read
   task automatic fetch(input logic [31:0] a, input logic c, input int kind);
      int n;
      int f0;
      int s0;
      n = 0;
      f0 = n_fill;
      s0 = n_single;
      @(posedge clk_i);
      fetch_req_i <= 1'b1;
      fetch_addr_i <= a;
      fetch_cacheable_i <= c;
      do @(negedge clk_i); while (fetch_ready_o !== 1'b1);
      @(posedge clk_i);
      fetch_req_i <= 1'b0;
      do begin
         @(negedge clk_i);
         n++;
      end while (fetch_valid_o !== 1'b1 && n < 300);
      cmp_word("fetch valid", 32'h1, {31'h0, fetch_valid_o});
      cmp_word("fetch data", mem_word(a), fetch_data_o);
      cmp_kind("fetch source", kind, (n_fill - f0) + 2 * (n_single - s0));
   endtask
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      summarize;
   end
   initial begin
      {rst_i, soft_rst_i, sleep_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, fetch_req_i, fetch_cacheable_i} = 8'h80;
      {wb_adr_i, wb_dat_i, fetch_addr_i, gap} = 76'h0;
      wb_sel_i = 4'hF;
      hw_reset;
      reg_chk(`IC_REG_CTRL, 32'h0);
      reg_chk(8'h40, 32'h0);
      fetch(32'h0000_0104, 1'b1, 2);
      fetch(32'h0000_0104, 1'b1, 2);
      bus(1'b1, `IC_REG_CTRL, 32'h0000_1001);
      reg_chk(`IC_REG_STATUS, 32'h3);
      fetch(32'h0000_0104, 1'b1, 1);
      fetch(32'h0000_0118, 1'b1, 0);
      fetch(32'h0000_011C, 1'b0, 0);
      fetch(32'h0000_8010, 1'b0, 2);
      fetch(32'h0000_8010, 1'b0, 2);
      // Fill every way of set 3, then one line more
      for (int i = 1; i <= 33; i++)
         fetch((32'(i) << 9) | 32'h0000_0060, 1'b1, 1);
      fetch(32'h0000_0460, 1'b1, 0);
      fetch(32'h0000_0260, 1'b1, 1);
      fetch(32'h0000_0460, 1'b1, 1);
      fetch(32'h0000_0860, 1'b1, 0);
      reg_chk(`IC_REG_STATUS, 32'hB);
      reg_chk(`IC_REG_HITS, 32'h4);
      reg_chk(`IC_REG_MISSES, 32'h28);
      bus(1'b1, `IC_REG_CTRL, 32'h0000_1000);
      fetch(32'h0000_2000, 1'b0, 1);
      bus(1'b1, `IC_REG_CACHEOP, 32'h4);
      fetch(32'h0000_0104, 1'b1, 0);
      bus(1'b1, `IC_REG_CACHEOP, {28'h0, `IC_OP_INV_ALL});
      fetch(32'h0000_0104, 1'b1, 1);
      bus(1'b1, `IC_REG_CTRL, 32'h0000_1001);
      @(posedge clk_i) soft_rst_i <= 1'b1;
      @(posedge clk_i) soft_rst_i <= 1'b0;
      reg_chk(`IC_REG_CTRL, 32'h1);
      fetch(32'h0000_0104, 1'b1, 0);
      fetch(32'h0000_4000, 1'b1, 2);
      bus(1'b1, `IC_REG_CTRL, 32'h0000_1001);
      @(posedge clk_i) sleep_rst_i <= 1'b1;
      @(posedge clk_i) sleep_rst_i <= 1'b0;
      reg_chk(`IC_REG_CTRL, 32'h1);
      gap <= 4'h3;
      bus(1'b1, `IC_REG_CTRL, 32'h0000_1001);
      fetch(32'h0000_6020, 1'b1, 1);
      bus(1'b1, `IC_REG_CTRL, 32'h0000_0001);
      fetch(32'h0000_6040, 1'b1, 2);
      @(posedge clk_i) hw_reset;
      reg_chk(`IC_REG_CTRL, 32'h0);
      reg_chk(`IC_REG_HITS, 32'h0);
      bus(1'b1, `IC_REG_CTRL, 32'h0000_1001);
      fetch(32'h0000_0104, 1'b1, 1);
      summarize;
   end
endmodule
